// [hdl/eec_pkg.sv]
/*
  Package for the EEPROM command and busy controller: register map, field
  layout, command codes, state encoding, timing counts and port structs.
  Assumes a 100 MHz pclk and an APB master with 32-bit data.
*/
package eec_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [11:0] ADDR_CMD  = 12'h0B0;
  localparam logic [11:0] ADDR_DATA = 12'h0B4;
  localparam logic [11:0] ADDR_STS  = 12'h0B8;
  localparam logic [11:0] ADDR_MSK  = 12'h0BC;
  localparam logic [11:0] ADDR_MACL = 12'h0C0;
  localparam logic [11:0] ADDR_MACH = 12'h0C4;

  // ==========================================================================
  // Fields of the command register
  // ==========================================================================
  localparam int BUSY_BIT = 31;
  localparam int CMD_LSB  = 28;
  localparam int TOUT_BIT = 9;

  localparam logic [2:0] CMD_READ   = 3'h0;
  localparam logic [2:0] CMD_WRITE  = 3'h3;
  localparam logic [2:0] CMD_RELOAD = 3'h7;

  // Interrupt status and mask bits.
  localparam int IRQ_DONE = 0;
  localparam int IRQ_TOUT = 1;

  // ==========================================================================
  // Reset values and MAC load layout
  // ==========================================================================
  localparam logic       BUSY_RST     = 1'b1;
  localparam logic [1:0] MSK_RST      = 2'h0;
  localparam logic [2:0] MAC_LAST_IDX = 3'h5;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_MHZ        = 100;
  localparam int TIMEOUT_MS     = 30;
  localparam int TIMEOUT_CYCLES = TIMEOUT_MS * 1000 * CLK_MHZ;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_REQ  = 2'b01,
    ST_REL  = 2'b11
  } eec_st_e;

  typedef struct packed
  {
    logic       req;
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } eec_ee_req_s;

  typedef struct packed
  {
    logic       ack;
    logic [7:0] rdata;
  } eec_ee_rsp_s;

endpackage : eec_pkg

// [hdl/eec_ctrl.sv]
/*
  EEPROM command and busy controller with an APB register slave, a four-phase
  request/acknowledge port towards the EEPROM interface, automatic MAC load
  after reset, a timeout on a silent EEPROM and a level interrupt.
  Assumes the EEPROM response pins are asynchronous to pclk and that rdata is
  stable whenever ack is high.
*/
// Added by the designer: the APB register port.
`timescale 1ns/100ps

// Functional notes
// - Writing one to busy runs the selected command at the given address.
// - Busy reads one throughout an operation and clears only when it ends.
// - Read data sits in the data register before busy clears.
// - A write with no EEPROM holds busy until timeout, then clears it.
// - Busy reads one straight after reset, before any command.
// - After reset the MAC is loaded automatically; busy clears when it ends.
module eec_ctrl #(
  parameter int unsigned TIMEOUT_CYCLES = eec_pkg::TIMEOUT_CYCLES
) (
  input  wire logic                 pclk,     // System clock, 100 MHz.
  input  wire logic                 presetn,  // Asynchronous reset, active low.
  input  wire logic                 psel,     // APB select.
  input  wire logic                 penable,  // APB enable.
  input  wire logic                 pwrite,   // APB direction, high for write.
  input  wire logic [11:0]          paddr,    // APB byte address.
  input  wire logic [31:0]          pwdata,   // APB write data.
  output logic      [31:0]          prdata,   // APB read data.
  output logic                      pready,   // APB ready.
  output logic                      pslverr,  // APB error on unmapped address.
  output logic                      irq,      // Level interrupt, active high.
  output eec_pkg::eec_ee_req_s      ee_req,   // Request towards the EEPROM.
  input  wire eec_pkg::eec_ee_rsp_s ee_rsp    // Response from the EEPROM pins.
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed
  {
    eec_pkg::eec_st_e     st;
    logic                 busy;
    logic                 load;
    logic [2:0]           idx;
    logic [2:0]           cmd;
    logic [7:0]           addr;
    logic [7:0]           data;
    logic [47:0]          mac;
    logic [1:0]           sts;
    logic [1:0]           msk;
    logic [23:0]          tmr;
    logic                 pready;
    logic                 pslverr;
    logic [31:0]          prdata;
    logic                 irq;
    eec_pkg::eec_ee_req_s req;
    eec_pkg::eec_ee_rsp_s s1;
    eec_pkg::eec_ee_rsp_s s2;
  } eec_state_s;

  localparam logic [23:0] TMR_LAST = 24'(TIMEOUT_CYCLES - 1);

  eec_state_s q;
  eec_state_s d;

  // ==========================================================================
  // Register decode
  // ==========================================================================
  function automatic logic reg_hit(input logic [11:0] a);
    reg_hit = (a == eec_pkg::ADDR_CMD)  || (a == eec_pkg::ADDR_DATA) ||
              (a == eec_pkg::ADDR_STS)  || (a == eec_pkg::ADDR_MSK)  ||
              (a == eec_pkg::ADDR_MACL) || (a == eec_pkg::ADDR_MACH);
  endfunction : reg_hit

  function automatic logic [31:0] rd_word(input logic [11:0] a, input eec_state_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      eec_pkg::ADDR_CMD:
      begin
        w[eec_pkg::BUSY_BIT]                   = s.busy;
        w[eec_pkg::CMD_LSB +: 3]               = s.cmd;
        w[eec_pkg::TOUT_BIT]                   = s.sts[eec_pkg::IRQ_TOUT];
        w[7:0]                                 = s.addr;
      end
      eec_pkg::ADDR_DATA: w[7:0]  = s.data;
      eec_pkg::ADDR_STS:  w[1:0]  = s.sts;
      eec_pkg::ADDR_MSK:  w[1:0]  = s.msk;
      eec_pkg::ADDR_MACL: w       = s.mac[31:0];
      eec_pkg::ADDR_MACH: w[15:0] = s.mac[47:32];
      default:            w       = 32'h0000_0000;
    endcase
    rd_word = w;
  endfunction : rd_word

  // ==========================================================================
  // Next state
  // ==========================================================================
  logic wr_ok;
  logic set_done;
  logic set_tout;
  logic fail;

  always_comb
  begin
    d        = q;
    set_done = 1'b0;
    set_tout = 1'b0;
    fail     = 1'b0;

    // Response pins pass two flip-flops; only s2 is used by logic.
    d.s1 = ee_rsp;
    d.s2 = q.s1;

    // Zero-wait APB: ready is raised for the access phase after setup.
    d.pready  = 1'b0;
    d.pslverr = 1'b0;
    if (psel && !penable)
    begin
      d.pready  = 1'b1;
      d.pslverr = !reg_hit(paddr);
      d.prdata  = pwrite ? 32'h0000_0000 : rd_word(paddr, q);
    end
    wr_ok = psel && penable && pwrite && q.pready && !q.pslverr;

    if (wr_ok)
    begin
      case (paddr)
        eec_pkg::ADDR_CMD:
        begin
          // Only a one starts; a zero, or any write while busy, is ignored.
          if (!q.busy && pwdata[eec_pkg::BUSY_BIT])
          begin
            d.busy = 1'b1;
            d.cmd  = pwdata[eec_pkg::CMD_LSB +: 3];
            d.addr = pwdata[7:0];
            if (pwdata[eec_pkg::CMD_LSB +: 3] == eec_pkg::CMD_RELOAD)
            begin
              d.load = 1'b1;
              d.idx  = 3'h0;
            end
          end
        end
        eec_pkg::ADDR_DATA:
        begin
          if (!q.busy)
          begin
            d.data = pwdata[7:0];
          end
        end
        eec_pkg::ADDR_STS: d.sts = q.sts & ~pwdata[1:0];
        eec_pkg::ADDR_MSK: d.msk = pwdata[1:0];
        default:           d.sts = d.sts;
      endcase
    end

    case (q.st)
      eec_pkg::ST_IDLE:
      begin
        if (q.busy && q.s2.ack)
        begin
          // A partner still holding ack after a timed-out release must let go
          // first, or its stale byte would be taken as the next answer.
          d.tmr = q.tmr + 24'h00_0001;
          if (q.tmr == TMR_LAST)
          begin
            fail = 1'b1;
          end
        end
        else if (q.busy)
        begin
          if (q.load)
          begin
            // Automatic MAC load, one byte per handshake.
            d.req.req   = 1'b1;
            d.req.we    = 1'b0;
            d.req.addr  = {5'h00, q.idx};
            d.req.wdata = 8'h00;
            d.tmr       = 24'h00_0000;
            d.st        = eec_pkg::ST_REQ;
          end
          else if (q.cmd == eec_pkg::CMD_READ || q.cmd == eec_pkg::CMD_WRITE)
          begin
            d.req.req   = 1'b1;
            d.req.we    = (q.cmd == eec_pkg::CMD_WRITE);
            d.req.addr  = q.addr;
            d.req.wdata = q.data;
            d.tmr       = 24'h00_0000;
            d.st        = eec_pkg::ST_REQ;
          end
          else
          begin
            // An unsupported command completes at once with no EEPROM access.
            d.busy   = 1'b0;
            set_done = 1'b1;
          end
        end
      end
      eec_pkg::ST_REQ:
      begin
        d.tmr = q.tmr + 24'h00_0001;
        if (q.s2.ack)
        begin
          if (!q.req.we && q.load)
          begin
            d.mac[q.idx * 8 +: 8] = q.s2.rdata;
          end
          else if (!q.req.we)
          begin
            d.data = q.s2.rdata;
          end
          d.req.req = 1'b0;
          d.tmr     = 24'h00_0000;
          d.st      = eec_pkg::ST_REL;
        end
        else if (q.tmr == TMR_LAST)
        begin
          fail = 1'b1;
        end
      end
      eec_pkg::ST_REL:
      begin
        d.tmr = q.tmr + 24'h00_0001;
        if (!q.s2.ack)
        begin
          d.st  = eec_pkg::ST_IDLE;
          d.tmr = 24'h00_0000;
          if (q.load && q.idx != eec_pkg::MAC_LAST_IDX)
          begin
            d.idx = q.idx + 3'h1;
          end
          else
          begin
            d.busy   = 1'b0;
            d.load   = 1'b0;
            set_done = 1'b1;
          end
        end
        else if (q.tmr == TMR_LAST)
        begin
          fail = 1'b1;
        end
      end
      default:
      begin
        d.st = eec_pkg::ST_IDLE;
      end
    endcase

    // A silent EEPROM ends the operation, or the MAC load, with busy clear.
    if (fail)
    begin
      d.req.req = 1'b0;
      d.busy    = 1'b0;
      d.load    = 1'b0;
      // The count restarts so that a later wait for a stuck ack is timed
      // from zero and not from what this operation left behind.
      d.tmr     = 24'h00_0000;
      set_tout  = 1'b1;
      d.st      = eec_pkg::ST_IDLE;
    end

    // Set wins over a same-cycle write-one-to-clear.
    if (set_done)
    begin
      d.sts[eec_pkg::IRQ_DONE] = 1'b1;
    end
    if (set_tout)
    begin
      d.sts[eec_pkg::IRQ_TOUT] = 1'b1;
    end
    d.irq = |(d.sts & d.msk);
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q      <= '0;
      q.busy <= eec_pkg::BUSY_RST;
      q.load <= 1'b1;
      q.msk  <= eec_pkg::MSK_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign prdata  = q.prdata;
  assign pready  = q.pready;
  assign pslverr = q.pslverr;
  assign irq     = q.irq;
  assign ee_req  = q.req;

endmodule : eec_ctrl

// [sim/eec_ctrl_sva.sv]
/* Port checker for eec_ctrl. Assumes one pclk domain and an APB master. */
`timescale 1ns/100ps
module eec_ctrl_sva #(
  parameter int unsigned TIMEOUT_CYCLES = 50
) (
  input wire logic                 pclk,    // Clock.
  input wire logic                 presetn, // Reset.
  input wire logic                 psel,    // Select.
  input wire logic                 penable, // Enable.
  input wire logic                 pwrite,  // Direction.
  input wire logic [11:0]          paddr,   // Address.
  input wire logic [31:0]          pwdata,  // Write data.
  input wire logic [31:0]          prdata,  // Read data.
  input wire logic                 pready,  // Ready.
  input wire logic                 pslverr, // Error.
  input wire logic                 irq,     // Interrupt.
  input wire eec_pkg::eec_ee_req_s ee_req,  // Request.
  input wire eec_pkg::eec_ee_rsp_s ee_rsp   // Response.
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // Request length counter
  // ==========================================================================
  logic [31:0] req_cnt_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      req_cnt_q <= 32'h0;
    else
      req_cnt_q <= ee_req.req ? req_cnt_q + 32'h1 : 32'h0;
  load_start_a: assert property ($rose(presetn) |-> ##[1:2] ee_req.req && !ee_req.we)
    else $error("load not started after reset");
  rdy_after_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  rdy_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_with_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  req_hold_a: assert property (ee_req.req && $past(ee_req.req) |-> $stable(ee_req.addr))
    else $error("request address moved");
  req_drop_a: assert property ($rose(ee_rsp.ack) |-> ##[1:6] !ee_req.req)
    else $error("request held after ack");
  tout_end_a: assert property (req_cnt_q <= TIMEOUT_CYCLES + 8)
    else $error("request outlived timeout");
endmodule : eec_ctrl_sva
bind eec_ctrl eec_ctrl_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_sva (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .ee_req, .ee_rsp);

// [sim/eec_ee_model.sv]
/* Behavioural EEPROM on the request port. Assumes a four-phase handshake. */
`timescale 1ns/100ps
module eec_ee_model (
  input wire logic                 pclk,    // Clock.
  input wire logic                 present, // EEPROM fitted.
  input wire logic [3:0]           lag,     // Answer delay.
  input wire eec_pkg::eec_ee_req_s req,     // Request.
  output eec_pkg::eec_ee_rsp_s     rsp      // Response.
);
  logic [7:0] mem [256];
  logic [3:0] cnt;
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5A;
    rsp = '0;
    cnt = 4'h0;
  end
  always @(posedge pclk)
    if (rsp.ack)
    begin
      if (!req.req)
      begin
        rsp.ack <= 1'b0;
        // Released data is not held, so stale bytes are never mistaken.
        rsp.rdata <= ~rsp.rdata;
      end
    end
    else if (req.req && present)
    begin
      cnt <= cnt + 4'h1;
      if (cnt >= lag)
      begin
        cnt <= 4'h0;
        if (req.we)
          mem[req.addr] <= req.wdata;
        rsp.ack <= 1'b1;
        rsp.rdata <= mem[req.addr];
      end
    end
endmodule : eec_ee_model

// [sim/eeprom_command_busy_control_tb.sv]
/* Bench for eec_ctrl with an EEPROM model. Assumes a 100 MHz pclk. */
`timescale 1ns/100ps
module eeprom_command_busy_control_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, present, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] lag;
  eec_pkg::eec_ee_req_s ee_req;
  eec_pkg::eec_ee_rsp_s ee_rsp;
  int num_errors, compares, n;
  eec_ctrl #(.TIMEOUT_CYCLES(50)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq, .ee_req, .ee_rsp);
  eec_ee_model u_ee (.pclk, .present, .lag, .req(ee_req), .rsp(ee_rsp));
  always #5 pclk = ~pclk;
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic idle;
    n = 0;
    do
    begin
      bus(1'b0, eec_pkg::ADDR_CMD, 32'h0);
      n++;
    end
    while (r[31] !== 1'b0 && n < 300);
  endtask : idle
  task automatic tally_and_finish;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    tally_and_finish;
  end
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, num_errors, compares} = '0;
    present = 1'b1;
    lag = 4'h1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b0, eec_pkg::ADDR_CMD, 32'h0);
    chk("busy_rst", r[31], 1'b1);
    idle;
    chk("load_end", r[31], 1'b0);
    bus(1'b0, eec_pkg::ADDR_MACL, 32'h0);
    chk("mac_lo", r, 32'h59585B5A);
    bus(1'b0, eec_pkg::ADDR_MACH, 32'h0);
    chk("mac_hi", r, 32'h00005F5E);
    $display("test load done");
    lag <= 4'h6;
    bus(1'b1, eec_pkg::ADDR_DATA, 32'h0000003C);
    bus(1'b1, eec_pkg::ADDR_CMD, {1'b1, eec_pkg::CMD_WRITE, 20'h0, 8'h10});
    bus(1'b1, eec_pkg::ADDR_CMD, 32'h0);
    bus(1'b0, eec_pkg::ADDR_CMD, 32'h0);
    chk("busy_hold", r[31], 1'b1);
    idle;
    chk("ee_byte", u_ee.mem[8'h10], 8'h3C);
    bus(1'b1, eec_pkg::ADDR_CMD, {1'b0, eec_pkg::CMD_READ, 20'h0, 8'h10});
    bus(1'b0, eec_pkg::ADDR_CMD, 32'h0);
    chk("zero_idle", r[31], 1'b0);
    bus(1'b1, eec_pkg::ADDR_DATA, 32'h0);
    bus(1'b1, eec_pkg::ADDR_CMD, {1'b1, eec_pkg::CMD_READ, 20'h0, 8'h10});
    idle;
    bus(1'b0, eec_pkg::ADDR_DATA, 32'h0);
    chk("rd_data", r[7:0], 8'h3C);
    $display("test write read done");
    bus(1'b1, eec_pkg::ADDR_DATA, 32'h000000A5);
    bus(1'b1, eec_pkg::ADDR_CMD, {1'b1, eec_pkg::CMD_WRITE, 20'h0, 8'h00});
    idle;
    bus(1'b1, eec_pkg::ADDR_CMD, {1'b1, eec_pkg::CMD_RELOAD, 20'h0, 8'h00});
    idle;
    bus(1'b0, eec_pkg::ADDR_MACL, 32'h0);
    chk("mac_reload", r, 32'h59585BA5);
    $display("test reload done");
    bus(1'b1, eec_pkg::ADDR_MSK, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_on", irq, 1'b1);
    bus(1'b1, eec_pkg::ADDR_MSK, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq_mask", irq, 1'b0);
    bus(1'b1, eec_pkg::ADDR_STS, 32'h3);
    bus(1'b0, eec_pkg::ADDR_STS, 32'h0);
    chk("sts_clr", r, 32'h0);
    $display("test irq done");
    present <= 1'b0;
    bus(1'b1, eec_pkg::ADDR_CMD, {1'b1, eec_pkg::CMD_WRITE, 20'h0, 8'h20});
    idle;
    chk("tout_wait", n >= 15 && n < 300, 1'b1);
    chk("tout_flag", r[9], 1'b1);
    bus(1'b0, 12'h000, 32'h0);
    chk("unmapped", err, 1'b1);
    $display("test timeout done");
    present <= 1'b1;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b0, eec_pkg::ADDR_CMD, 32'h0);
    chk("busy_rst2", r[31], 1'b1);
    idle;
    chk("load_end2", r[31], 1'b0);
    bus(1'b0, eec_pkg::ADDR_MACL, 32'h0);
    chk("mac_rst2", r, 32'h59585BA5);
    $display("test reset done");
    tally_and_finish;
  end
endmodule : eeprom_command_busy_control_tb
